/* File: hdl/lcr_top.sv */
// Purpose: Configuration registers, strap capture and lane routing control.
// Assumes: All inputs but the asynchronous rstn synchronous to clk; the serial-bus byte engine is outside
//          and presents one decoded byte write or read at a time.
// Notes:   Straps are captured once, on the first edge after reset release.
`timescale 1ns/100ps
module lcr_top
    import lcr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // Configuration select and straps.
    input  wire logic                 pin_mode_select,
    input  wire logic                 loopback_strap_n,
    input  wire logic                 powerdown_strap_n,
    input  wire logic                 group_a_deemph_mode,
    input  wire logic                 group_b_deemph_mode,
    input  wire logic [2:0]           group_a_eq_level_select,
    input  wire logic [2:0]           group_b_eq_level_select,
    input  wire logic [1:0]           group_a_swing_select,
    input  wire logic [1:0]           group_b_swing_select,
    input  wire logic [2:0]           group_a_deemph_level_select,
    input  wire logic [2:0]           group_b_deemph_level_select,
    // Decoded register access from the serial-bus byte engine.
    input  wire logic                 reg_wr_en,
    input  wire logic [IDX_W-1:0]     reg_wr_index,
    input  wire logic [7:0]           reg_wr_data,
    input  wire logic                 reg_rd_en,
    input  wire logic [IDX_W-1:0]     reg_rd_index,
    output logic [7:0]                reg_rd_data,
    output logic                      reg_rd_valid,
    output logic                      reg_access_enabled,
    // Lane data, detect and buffer control.
    input  wire logic [NUM_LANES-1:0] chan_a_receive,
    input  wire logic [NUM_LANES-1:0] chan_b_receive,
    input  wire logic [NUM_LANES-1:0] chan_a_sig,
    input  wire logic [NUM_LANES-1:0] chan_b_sig,
    output logic [NUM_LANES-1:0]      chan_a_transmit,
    output logic [NUM_LANES-1:0]      chan_b_transmit,
    output logic [NUM_LANES-1:0]      chan_a_tx_en,
    output logic [NUM_LANES-1:0]      chan_b_tx_en,
    output logic [NUM_LANES-1:0]      chan_a_squelch,
    output logic [NUM_LANES-1:0]      chan_b_squelch,
    // Applied group settings to the analog front end.
    output logic [2:0]                group_a_eq_level,
    output logic [2:0]                group_b_eq_level,
    output logic [1:0]                group_a_swing,
    output logic [1:0]                group_b_swing,
    output logic [2:0]                group_a_deemph_level,
    output logic [2:0]                group_b_deemph_level,
    output logic                      group_a_half_bit,
    output logic                      group_b_half_bit
);

    // -------------------------------------------------------------------------
    // Startup capture sequencer
    // -------------------------------------------------------------------------
    lcr_state_t state_q;
    lcr_state_t state_d;
    logic       capture;

    always_comb begin
        capture = 1'b0;
        case (state_q)
            ST_CAPTURE: begin
                capture = 1'b1;
                state_d = ST_RUN;
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_CAPTURE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_CAPTURE;
        end else begin
            state_q <= state_d;
        end
    end

    // -------------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------------
    logic [7:0] loopde_q, loopde_d;
    logic [7:0] inoff_q,  inoff_d;
    logic [7:0] outoff_q, outoff_d;
    logic [7:0] rsvd5_q,  rsvd5_d;
    logic [7:0] pwr_q,    pwr_d;
    logic [7:0] grpa_q,   grpa_d;
    logic [7:0] grpb_q,   grpb_d;
    logic       wr_ok;

    // The select level is used as it stands each cycle, never held.
    assign wr_ok              = reg_wr_en && !pin_mode_select && !capture;
    assign reg_access_enabled = !pin_mode_select;

    always_comb begin
        loopde_d = loopde_q;
        inoff_d  = inoff_q;
        outoff_d = outoff_q;
        rsvd5_d  = rsvd5_q;
        pwr_d    = pwr_q;
        grpa_d   = grpa_q;
        grpb_d   = grpb_q;
        if (capture) begin
            // The straps seed the registers once, whatever the select level.
            loopde_d = {{4{loopback_strap_n}}, group_a_deemph_mode,
                        group_b_deemph_mode, 2'b00};
            pwr_d    = {8{powerdown_strap_n}};
            grpa_d   = {group_a_eq_level_select, group_a_deemph_level_select,
                        group_a_swing_select};
            grpb_d   = {group_b_eq_level_select, group_b_deemph_level_select,
                        group_b_swing_select};
        end else if (wr_ok) begin
            case (reg_wr_index)
                IDX_LOOPDE: loopde_d = {reg_wr_data[7:2], 2'b00};
                IDX_INOFF:  inoff_d  = reg_wr_data;
                IDX_OUTOFF: outoff_d = reg_wr_data;
                IDX_RSVD5:  rsvd5_d  = reg_wr_data;
                IDX_PWR:    pwr_d    = reg_wr_data;
                IDX_GRPA:   grpa_d   = reg_wr_data;
                IDX_GRPB:   grpb_d   = reg_wr_data;
                default:    ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loopde_q <= {RST_LOOP_N, RST_DEMODE};
            inoff_q  <= RST_INOFF;
            outoff_q <= RST_OUTOFF;
            rsvd5_q  <= RST_RSVD5;
            pwr_q    <= RST_BYTE;
            grpa_q   <= RST_BYTE;
            grpb_q   <= RST_BYTE;
        end else begin
            loopde_q <= loopde_d;
            inoff_q  <= inoff_d;
            outoff_q <= outoff_d;
            rsvd5_q  <= rsvd5_d;
            pwr_q    <= pwr_d;
            grpa_q   <= grpa_d;
            grpb_q   <= grpb_d;
        end
    end

    // -------------------------------------------------------------------------
    // Applied settings: straps in pin mode, registers otherwise
    // -------------------------------------------------------------------------
    logic [NUM_LANES-1:0] eff_loop_n;
    logic [7:0]           eff_inoff;
    logic [7:0]           eff_outoff;
    logic [7:0]           eff_pwr;
    logic [7:0]           eff_grpa;
    logic [7:0]           eff_grpb;
    logic                 eff_dea;
    logic                 eff_deb;
    logic [7:0]           sig_byte;
    logic [17:0]          grp_d;
    logic [17:0]          grp_q;

    always_comb begin
        sig_byte = 8'h00;
        for (int i = 0; i < NUM_LANES; i++) begin
            eff_loop_n[i]          = loopde_q[LOOP_MSB-i];
            sig_byte[CHAN_MSB-2*i] = chan_a_sig[i];
            sig_byte[CHAN_MSB-2*i-1] = chan_b_sig[i];
        end
        eff_inoff  = inoff_q;
        eff_outoff = outoff_q;
        eff_pwr    = pwr_q;
        eff_grpa   = grpa_q;
        eff_grpb   = grpb_q;
        eff_dea    = loopde_q[DEMODE_A];
        eff_deb    = loopde_q[DEMODE_B];
        if (pin_mode_select) begin
            // Pin control has no disable pins, so no input or output disable applies; only the powerdown strap turns buffers off.
            eff_loop_n = {NUM_LANES{loopback_strap_n}};
            eff_inoff  = RST_INOFF;
            eff_outoff = RST_OUTOFF;
            eff_pwr    = {8{powerdown_strap_n}};
            eff_grpa   = {group_a_eq_level_select, group_a_deemph_level_select,
                          group_a_swing_select};
            eff_grpb   = {group_b_eq_level_select, group_b_deemph_level_select,
                          group_b_swing_select};
            eff_dea    = group_a_deemph_mode;
            eff_deb    = group_b_deemph_mode;
        end
        // One setting per group feeds all four channels of that group.
        grp_d = {eff_grpa[EQ_LSB +: 3], eff_grpb[EQ_LSB +: 3],
                 eff_grpa[SW_LSB +: 2], eff_grpb[SW_LSB +: 2],
                 eff_grpa[DEL_LSB +: 3], eff_grpb[DEL_LSB +: 3],
                 eff_dea, eff_deb};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            grp_q <= 18'h00000;
        end else begin
            grp_q <= grp_d;
        end
    end

    assign group_a_eq_level     = grp_q[17:15];
    assign group_b_eq_level     = grp_q[14:12];
    assign group_a_swing        = grp_q[11:10];
    assign group_b_swing        = grp_q[9:8];
    assign group_a_deemph_level = grp_q[7:5];
    assign group_b_deemph_level = grp_q[4:2];
    assign group_a_half_bit     = grp_q[1];
    assign group_b_half_bit     = grp_q[0];

    // -------------------------------------------------------------------------
    // Register read port
    // -------------------------------------------------------------------------
    logic [7:0] rd_d;
    logic [7:0] rd_q;
    logic       rdv_q;

    always_comb begin
        case (reg_rd_index)
            IDX_SIGDET: rd_d = sig_byte;
            IDX_LOOPDE: rd_d = loopde_q;
            IDX_INOFF:  rd_d = inoff_q;
            IDX_OUTOFF: rd_d = outoff_q;
            IDX_RSVD5:  rd_d = rsvd5_q;
            IDX_PWR:    rd_d = pwr_q;
            IDX_GRPA:   rd_d = grpa_q;
            IDX_GRPB:   rd_d = grpb_q;
            default:    rd_d = RD_RSVD;
        endcase
        if (!reg_rd_en) begin
            rd_d = rd_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_q  <= RD_RSVD;
            rdv_q <= 1'b0;
        end else begin
            rd_q  <= rd_d;
            rdv_q <= reg_rd_en && !pin_mode_select;
        end
    end

    assign reg_rd_data  = rd_q;
    assign reg_rd_valid = rdv_q;

    // -------------------------------------------------------------------------
    // Lane routing
    // -------------------------------------------------------------------------
    // Loopback is meant to be set once; a change mid-traffic simply reroutes
    // on the next cycle with no glitch protection.
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        lcr_lane_route u_route (
            .clk               (clk),
            .rstn              (rstn),
            .lane_loop_n       (eff_loop_n[g]),
            .chan_a_input_off  (eff_inoff[CHAN_MSB-2*g]),
            .chan_b_input_off  (eff_inoff[CHAN_MSB-2*g-1]),
            .chan_a_output_off (eff_outoff[CHAN_MSB-2*g]),
            .chan_b_output_off (eff_outoff[CHAN_MSB-2*g-1]),
            .chan_a_pwr_n      (eff_pwr[CHAN_MSB-2*g]),
            .chan_b_pwr_n      (eff_pwr[CHAN_MSB-2*g-1]),
            .chan_a_receive    (chan_a_receive[g]),
            .chan_b_receive    (chan_b_receive[g]),
            .chan_a_sig        (chan_a_sig[g]),
            .chan_b_sig        (chan_b_sig[g]),
            .chan_a_transmit   (chan_a_transmit[g]),
            .chan_b_transmit   (chan_b_transmit[g]),
            .chan_a_tx_en      (chan_a_tx_en[g]),
            .chan_b_tx_en      (chan_b_tx_en[g]),
            .chan_a_squelch    (chan_a_squelch[g]),
            .chan_b_squelch    (chan_b_squelch[g])
        );
    end

endmodule : lcr_top

/* File: include/lcr_pkg.sv */
// Purpose: Shared constants for the lane configuration and routing control block.
// Assumes: Register writes and reads arrive as decoded byte accesses from an
//          external serial-bus byte engine.
// Notes:   Byte indices follow the device's configuration byte order.
package lcr_pkg;

    localparam int unsigned NUM_LANES   = 4;
    localparam int unsigned IDX_W       = 4;

    // -------------------------------------------------------------------------
    // Register byte indices
    // -------------------------------------------------------------------------
    localparam logic [3:0] IDX_SIGDET   = 4'h0;
    localparam logic [3:0] IDX_RSVD1    = 4'h1;
    localparam logic [3:0] IDX_LOOPDE   = 4'h2;
    localparam logic [3:0] IDX_INOFF    = 4'h3;
    localparam logic [3:0] IDX_OUTOFF   = 4'h4;
    localparam logic [3:0] IDX_RSVD5    = 4'h5;
    localparam logic [3:0] IDX_PWR      = 4'h6;
    localparam logic [3:0] IDX_RSVD7    = 4'h7;
    localparam logic [3:0] IDX_GRPA     = 4'h8;
    localparam logic [3:0] IDX_GRPB     = 4'h9;

    // -------------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------------
    // Loop/de-emphasis byte: lane i loop bit at LOOP_MSB - i.
    localparam int unsigned LOOP_MSB    = 7;
    localparam int unsigned DEMODE_A    = 3;
    localparam int unsigned DEMODE_B    = 2;
    // Per-channel bytes: lane i A channel at CHAN_MSB - 2i, B channel one below.
    localparam int unsigned CHAN_MSB    = 7;
    // Group bytes: equaliser, de-emphasis level, swing.
    localparam int unsigned EQ_LSB      = 5;
    localparam int unsigned DEL_LSB     = 2;
    localparam int unsigned SW_LSB      = 0;

    // -------------------------------------------------------------------------
    // Reset values; the strap capture overwrites the loop, power and group bytes
    // -------------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] RST_INOFF    = 8'h00;
    localparam logic [7:0] RST_OUTOFF   = 8'h00;
    localparam logic [7:0] RST_RSVD5    = 8'hff;
    localparam logic [3:0] RST_LOOP_N   = 4'hf;
    // Both groups start at half-bit de-emphasis; the two reserved bits read 0.
    localparam logic [3:0] RST_DEMODE   = 4'hc;
    localparam logic [7:0] RD_RSVD      = 8'h00;

    // -------------------------------------------------------------------------
    // Startup sequencing
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b01,
        ST_RUN     = 2'b10
    } lcr_state_t;

endpackage : lcr_pkg

/* File: hdl/lcr_lane_route.sv */
// Purpose: Routing, disable and squelch for one lane (A and B channel pair).
// Assumes: Controls are already resolved between strap and register sources.
// Notes:   Outputs are registered.
`timescale 1ns/100ps
module lcr_lane_route
    import lcr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic lane_loop_n,
    input  wire logic chan_a_input_off,
    input  wire logic chan_b_input_off,
    input  wire logic chan_a_output_off,
    input  wire logic chan_b_output_off,
    input  wire logic chan_a_pwr_n,
    input  wire logic chan_b_pwr_n,
    input  wire logic chan_a_receive,
    input  wire logic chan_b_receive,
    input  wire logic chan_a_sig,
    input  wire logic chan_b_sig,
    output logic      chan_a_transmit,
    output logic      chan_b_transmit,
    output logic      chan_a_tx_en,
    output logic      chan_b_tx_en,
    output logic      chan_a_squelch,
    output logic      chan_b_squelch
);

    logic a_live;
    logic b_live;
    logic b_src_data;
    logic b_src_live;
    logic b_src_sig;
    logic [5:0] out_d;
    logic [5:0] out_q;

    always_comb begin
        a_live     = chan_a_pwr_n && !chan_a_input_off;
        b_live     = chan_b_pwr_n && !chan_b_input_off;
        // Normal flow keeps each path straight; loopback feeds A into B as well.
        b_src_data = lane_loop_n ? chan_b_receive : chan_a_receive;
        b_src_live = lane_loop_n ? b_live : a_live;
        b_src_sig  = lane_loop_n ? chan_b_sig : chan_a_sig;
        out_d[0]   = chan_a_receive;
        out_d[1]   = b_src_data;
        out_d[2]   = a_live && chan_a_pwr_n && !chan_a_output_off;
        out_d[3]   = b_src_live && chan_b_pwr_n && !chan_b_output_off;
        out_d[4]   = !chan_a_sig;
        out_d[5]   = !b_src_sig;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_q <= 6'h00;
        end else begin
            out_q <= out_d;
        end
    end

    assign chan_a_transmit = out_q[0];
    assign chan_b_transmit = out_q[1];
    assign chan_a_tx_en    = out_q[2];
    assign chan_b_tx_en    = out_q[3];
    assign chan_a_squelch  = out_q[4];
    assign chan_b_squelch  = out_q[5];

endmodule : lcr_lane_route

/* File: verif/lcr_top_sva.sv */
// Purpose: Port-level assertions for the lane configuration and routing block.
// Assumes: One clock domain; rstn is asynchronous and active low.
// Notes:   Pin-mode checks wait three edges so the strap capture cycle is excluded.
`timescale 1ns/100ps
module lcr_top_sva (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       pin_mode_select,
    input wire logic       loopback_strap_n,
    input wire logic       powerdown_strap_n,
    input wire logic       group_a_deemph_mode,
    input wire logic [2:0] group_a_eq_level_select,
    input wire logic [1:0] group_b_swing_select,
    input wire logic       reg_rd_en,
    input wire logic       reg_rd_valid,
    input wire logic       reg_access_enabled,
    input wire logic [3:0] chan_a_receive,
    input wire logic [3:0] chan_b_receive,
    input wire logic [3:0] chan_a_sig,
    input wire logic [3:0] chan_a_transmit,
    input wire logic [3:0] chan_b_transmit,
    input wire logic [3:0] chan_a_tx_en,
    input wire logic [3:0] chan_a_squelch,
    input wire logic [2:0] group_a_eq_level,
    input wire logic [1:0] group_b_swing,
    input wire logic       group_a_half_bit
);
    logic [1:0] up_q;
    logic [1:0] up_d;
    logic       pm_q;
    logic       pm_d;
    logic       run;
    logic       pin;
    always_comb begin
        up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
        pm_d = pin_mode_select;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            up_q <= 2'h0;
            pm_q <= 1'b0;
        end else begin
            up_q <= up_d;
            pm_q <= pm_d;
        end
    end
    assign run = (up_q == 2'h3);
    assign pin = run && pm_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_acc; reg_access_enabled == !pin_mode_select; endproperty
    a_acc: assert property (p_acc) else $error("access flag wrong");
    property p_eq; pin |-> group_a_eq_level == $past(group_a_eq_level_select); endproperty
    a_eq: assert property (p_eq) else $error("eq not from strap");
    property p_sw; pin |-> group_b_swing == $past(group_b_swing_select); endproperty
    a_sw: assert property (p_sw) else $error("swing not from strap");
    property p_half; pin |-> group_a_half_bit == $past(group_a_deemph_mode); endproperty
    a_half: assert property (p_half) else $error("half-bit wrong");
    property p_bsrc; pin && $past(powerdown_strap_n) |-> chan_b_transmit ==
        ($past(loopback_strap_n) ? $past(chan_b_receive) : $past(chan_a_receive)); endproperty
    a_bsrc: assert property (p_bsrc) else $error("b source wrong");
    property p_asrc; run |-> (chan_a_transmit & chan_a_tx_en) ==
        ($past(chan_a_receive) & chan_a_tx_en); endproperty
    a_asrc: assert property (p_asrc) else $error("a source wrong");
    property p_sq; run |-> chan_a_squelch == ~$past(chan_a_sig); endproperty
    a_sq: assert property (p_sq) else $error("squelch wrong");
    property p_vld; up_q != 2'h0 |-> reg_rd_valid == $past(reg_rd_en && !pin_mode_select);
    endproperty
    a_vld: assert property (p_vld) else $error("read valid wrong");
endmodule : lcr_top_sva

bind lcr_top lcr_top_sva i_lcr_top_sva (.*);

/* File: verif/lcr_host_model.sv */
// Purpose: Host model issuing decoded register byte writes and reads.
// Assumes: Drives on falling clock edges, one access at a time.
// Notes:   Released index and data show the inverse so stale values never match.
`timescale 1ns/100ps
module lcr_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_valid,
    output logic            reg_wr_en,
    output logic [3:0]      reg_wr_index,
    output logic [7:0]      reg_wr_data,
    output logic            reg_rd_en,
    output logic [3:0]      reg_rd_index
);
    initial begin
        {reg_wr_en, reg_rd_en} = 2'h0;
        {reg_wr_index, reg_rd_index, reg_wr_data} = 16'h0000;
    end
    // Unused buffers are switched off by writing the disable bytes.
    task automatic wr(input logic [3:0] idx, input logic [7:0] data);
        @(negedge clk);
        {reg_wr_en, reg_wr_index, reg_wr_data} = {1'b1, idx, data};
        @(negedge clk);
        {reg_wr_en, reg_wr_index, reg_wr_data} = {1'b0, ~idx, ~data};
    endtask : wr
    task automatic rd(input logic [3:0] idx, output logic [7:0] data, output logic vld);
        @(negedge clk);
        {reg_rd_en, reg_rd_index} = {1'b1, idx};
        @(negedge clk);
        data = reg_rd_data;
        vld = reg_rd_valid;
        {reg_rd_en, reg_rd_index} = {1'b0, ~idx};
    endtask : rd
endmodule : lcr_host_model

/* File: verif/test_lcr_top.sv */
// Purpose: Self-checking bench for the lane configuration and routing block.
// Assumes: Inputs change on falling clock edges; the host model drives register bytes.
// Notes:   Five loop and disable settings are swept on each lane in turn.
`timescale 1ns/100ps
module test_lcr_top
    import lcr_pkg::*;
;
    logic       clk, rstn, pin_mode_select, loopback_strap_n, powerdown_strap_n;
    logic       group_a_deemph_mode, group_b_deemph_mode, group_a_half_bit, group_b_half_bit;
    logic       reg_wr_en, reg_rd_en, reg_rd_valid, reg_access_enabled;
    logic [2:0] group_a_eq_level_select, group_b_eq_level_select, group_a_eq_level;
    logic [2:0] group_b_eq_level, group_a_deemph_level, group_b_deemph_level;
    logic [2:0] group_a_deemph_level_select, group_b_deemph_level_select;
    logic [1:0] group_a_swing_select, group_b_swing_select, group_a_swing, group_b_swing;
    logic [3:0] reg_wr_index, reg_rd_index, chan_a_receive, chan_b_receive, chan_a_sig;
    logic [3:0] chan_b_sig, chan_a_transmit, chan_b_transmit, chan_a_tx_en, chan_b_tx_en;
    logic [3:0] chan_a_squelch, chan_b_squelch;
    logic [7:0] reg_wr_data, reg_rd_data;
    int         fail_count = 0;
    int         checks = 0;
    lcr_top        i_lcr_top (.*);
    lcr_host_model i_lcr_host_model (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic finish_test();
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp, input logic ev);
        logic [7:0] d;
        logic       v;
        i_lcr_host_model.rd(idx, d, v);
        chk(d, exp);
        chk(8'(v), 8'(ev));
    endtask : rdchk
    task automatic t_capture();
        tick(2);
        rdchk(IDX_LOOPDE, 8'h08, 1'b1);
        rdchk(IDX_GRPA, 8'hb9, 1'b1);
        rdchk(IDX_GRPB, 8'h46, 1'b1);
        rdchk(IDX_PWR, 8'hff, 1'b1);
        chk(8'({group_a_half_bit, group_b_half_bit, group_a_eq_level}), 8'h15);
        group_a_eq_level_select = 3'h0;
        tick(2);
        chk(8'(group_a_eq_level), 8'h05);
    endtask : t_capture
    task automatic t_groups();
        for (int c = 0; c < 8; c++) begin
            logic [2:0] k;
            k = 3'(c);
            i_lcr_host_model.wr(IDX_GRPA, {k, ~k, k[1:0]});
            i_lcr_host_model.wr(IDX_GRPB, {~k, k, ~k[1:0]});
            tick(2);
            chk(8'({group_a_eq_level, group_b_eq_level}), 8'({k, ~k}));
            chk(8'({group_a_deemph_level, group_b_deemph_level}), 8'({~k, k}));
            chk(8'({group_a_swing, group_b_swing}), 8'({k[1:0], ~k[1:0]}));
        end
        i_lcr_host_model.wr(IDX_LOOPDE, 8'hf4);
        i_lcr_host_model.wr(4'ha, 8'h55);
        tick(2);
        chk(8'({group_a_half_bit, group_b_half_bit}), 8'h01);
        rdchk(4'ha, RD_RSVD, 1'b1);
    endtask : t_groups
    task automatic t_pin();
        {pin_mode_select, group_a_eq_level_select, group_a_deemph_mode} = 5'h14;
        tick(2);
        chk(8'({reg_access_enabled, group_a_eq_level, group_a_half_bit}), 8'h04);
        i_lcr_host_model.wr(IDX_GRPA, 8'h00);
        group_a_eq_level_select = 3'h6;
        tick(2);
        chk(8'(group_a_eq_level), 8'h06);
        rdchk(IDX_GRPA, 8'he3, 1'b0);
        pin_mode_select = 1'b0;
        tick(2);
        chk(8'({reg_access_enabled, group_a_eq_level}), 8'h0f);
    endtask : t_pin
    task automatic t_route();
        logic [4:0] md [5] = '{5'h10, 5'h04, 5'h06, 5'h15, 5'h1a};
        logic [7:0] lb, inb, outb;
        logic [3:0] ea, eb, etx;
        {chan_a_receive, chan_b_receive} = 8'ha5;
        for (int i = 0; i < 4; i++) begin
            for (int m = 0; m < 5; m++) begin
                {lb, inb, outb, ea, eb, etx} = {24'hfc0000, 8'hff, chan_b_receive};
                lb[7 - i] = md[m][4];
                {inb[7 - 2 * i], inb[6 - 2 * i]} = md[m][3:2];
                {outb[7 - 2 * i], outb[6 - 2 * i]} = md[m][1:0];
                ea[i] = !(md[m][3] | md[m][1]);
                eb[i] = !((md[m][4] ? md[m][2] : md[m][3]) | md[m][0]);
                etx[i] = md[m][4] ? chan_b_receive[i] : chan_a_receive[i];
                // Loop bits are set before traffic is judged, never mid-check.
                i_lcr_host_model.wr(IDX_LOOPDE, lb);
                i_lcr_host_model.wr(IDX_INOFF, inb);
                i_lcr_host_model.wr(IDX_OUTOFF, outb);
                tick(2);
                chk(8'({chan_a_tx_en, chan_b_tx_en}), 8'({ea, eb}));
                chk(8'(chan_b_transmit & eb), 8'(etx & eb));
            end
        end
        i_lcr_host_model.wr(IDX_INOFF, 8'h00);
        i_lcr_host_model.wr(IDX_OUTOFF, 8'h00);
    endtask : t_route
    task automatic t_strap();
        {chan_a_sig, chan_b_sig} = 8'h69;
        tick(2);
        chk(8'({chan_a_squelch, chan_b_squelch}), 8'h96);
        rdchk(IDX_SIGDET, 8'h69, 1'b1);
        i_lcr_host_model.wr(IDX_PWR, 8'h7f);
        tick(2);
        chk(8'({chan_a_tx_en, chan_b_tx_en}), 8'hef);
        pin_mode_select = 1'b1;
        tick(2);
        chk(8'({chan_b_transmit, chan_b_squelch}), 8'ha9);
        loopback_strap_n = 1'b1;
        tick(2);
        chk(8'({chan_b_transmit, chan_b_tx_en}), 8'h5f);
        powerdown_strap_n = 1'b0;
        tick(2);
        chk(8'({chan_a_tx_en, chan_b_tx_en}), 8'h00);
    endtask : t_strap
    initial begin
        rstn = 1'b0;
        {pin_mode_select, loopback_strap_n, powerdown_strap_n} = 3'h1;
        {group_a_deemph_mode, group_b_deemph_mode} = 2'h2;
        {group_a_eq_level_select, group_b_eq_level_select} = 6'h2a;
        {group_a_swing_select, group_b_swing_select} = 4'h6;
        {group_a_deemph_level_select, group_b_deemph_level_select} = 6'h31;
        {chan_a_receive, chan_b_receive, chan_a_sig, chan_b_sig} = 16'ha5ff;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_capture();
        t_groups();
        t_pin();
        t_route();
        t_strap();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        finish_test();
    end
endmodule : test_lcr_top
